// file: rtl/fieldbus_alarm_checker.sv
// Functional notes
// - transmit map over 32 bytes: alarm 85/0
// - receive map over 32 bytes: alarm 85/1
// - port link lost past time: alarm 85/2
// - ports down at init-to-preop are ignored until their link comes up
// - eeprom identity mismatch: alarm 85/3
// - eeprom access failure: alarm 85/3
// - sync0 event mapping bit set: alarm 85/3
// - pdi control not 0x0C08: alarm 85/3
// - sync config not 0x6600: alarm 85/3
// - sync pulse not 0x0064: alarm 85/3
// - irq map register nonzero: alarm 85/3
// - emergency stop input: alarm 87/0
`timescale 1ns/10ps
module fieldbus_alarm_checker
  import alarm_pkg::*;
#(
  parameter int TICK_CYCLES = LINK_UNIT_CYC  // cycles per lost-link time unit
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // fieldbus side
  input  wire logic [3:0]  esm_state,          // current fieldbus state
  input  wire logic [1:0]  port_link,          // link present, ports 1..0
  input  wire logic [31:0] eeprom_vendor_id,   // identity read from eeprom
  input  wire logic [31:0] eeprom_product,
  input  wire logic [31:0] eeprom_revision,
  input  wire logic        eeprom_access_fail, // pulse: read or write failed
  input  wire logic [15:0] pdi_control,        // controller regs 0x0140..0x0141
  input  wire logic [15:0] sync_config,        // controller reg 0x0150
  input  wire logic [7:0]  sync_event_map,     // controller reg 0x0151
  input  wire logic [7:0]  irq_map,            // controller reg 0x0152
  input  wire logic [15:0] sync_pulse,         // controller reg 0x0981
  input  wire logic        estop,              // forced alarm input, high active
  // drive alarm side
  output logic             alarm_valid,        // an alarm is latched
  output logic [7:0]       alarm_main,         // main number of first alarm
  output logic [7:0]       alarm_sub,          // sub number of first alarm
  output logic             irq                 // level interrupt
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // map size check is shared by both directions
  function automatic logic map_too_big(input logic [7:0] size);
    map_too_big = (size > MAP_LIMIT_BYTES);
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]            tx_size_q;       // transmit map size
  logic [7:0]            rx_size_q;       // receive map size
  logic [15:0]           link_time_q;     // lost_link_detect_time
  logic [31:0]           od_vendor_q;     // dictionary identity
  logic [31:0]           od_product_q;
  logic [31:0]           od_revision_q;
  logic [NUM_ALARMS-1:0] flags_q;         // reset-only sticky flags
  logic [NUM_ALARMS-1:0] int_status_q;    // read-clear status
  logic [NUM_ALARMS-1:0] int_mask_q;      // interrupt enables
  logic [NUM_ALARMS-1:0] events;          // this cycle's alarm causes
  logic [3:0]            esm_prev_q;      // state one cycle ago
  logic                  arm;             // init to preop pulse
  logic                  active;          // state is past init
  logic [1:0]            watch;           // per-port watch
  logic [1:0]            expired;         // per-port expiry pulse
  logic [15:0]           tick_cnt_q;      // unit divider
  logic                  tick_q;          // unit pulse
  logic                  aw_held_q;       // write address captured
  logic                  w_held_q;        // write data captured
  logic [7:0]            waddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  wr_go;           // both halves present
  logic                  wr_hit;          // write address mapped
  logic                  rd_go;           // read accepted
  logic                  rd_clear;        // read of the status register
  logic                  eeprom_bad;      // any eeprom alarm cause

  // ----------------------------------------------------------------
  // time unit divider
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end
    else if (tick_cnt_q == 16'(TICK_CYCLES - 1))
    begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      tick_q     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // fieldbus state tracking
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      esm_prev_q <= ESM_INIT;
    else
      esm_prev_q <= esm_state;
  end

  assign arm    = (esm_prev_q == ESM_INIT) && (esm_state == ESM_PREOP);
  assign active = (esm_state != ESM_INIT);

  // ----------------------------------------------------------------
  // per-port lost-link timers
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    lost_link_timer u_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick_q),
      .arm     (arm),
      .active  (active),
      .link_up (port_link[p]),
      .limit   (link_time_q),
      .watch   (watch[p]),
      .expired (expired[p])
    );
  end

  // ----------------------------------------------------------------
  // alarm causes
  // ----------------------------------------------------------------
  // controller register checks are levels: they keep re-setting the
  // status bit while the bad value stays, so a read cannot hide them
  always_comb
  begin
    eeprom_bad = 1'b0;
    if (eeprom_vendor_id != od_vendor_q || eeprom_product != od_product_q ||
        eeprom_revision != od_revision_q)
      eeprom_bad = 1'b1;
    if (eeprom_access_fail)
      eeprom_bad = 1'b1;
    if (sync_event_map[SYNC_MAP_BIT])
      eeprom_bad = 1'b1;
    if (pdi_control != PDI_CTRL_EXPECT)
      eeprom_bad = 1'b1;
    if (sync_config != SYNC_CFG_EXPECT)
      eeprom_bad = 1'b1;
    if (sync_pulse != SYNC_PULSE_EXPECT)
      eeprom_bad = 1'b1;
    if (irq_map != 8'h00)
      eeprom_bad = 1'b1;
  end

  always_comb
  begin
    events               = '0;
    events[AL_TX_MAP]    = map_too_big(tx_size_q);
    events[AL_RX_MAP]    = map_too_big(rx_size_q);
    events[AL_LOST_LINK] = |expired;
    events[AL_EEPROM]    = eeprom_bad;
    events[AL_ESTOP]     = estop;
  end

  // ----------------------------------------------------------------
  // latched alarms and first code
  // ----------------------------------------------------------------
  // flags only clear on reset; the code keeps the first alarm seen, with
  // the emergency stop preferred when several arrive together
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags_q     <= '0;
      alarm_valid <= 1'b0;
      alarm_main  <= 8'h00;
      alarm_sub   <= 8'h00;
    end
    else
    begin
      flags_q <= flags_q | events;
      if (!alarm_valid && |events)
      begin
        alarm_valid <= 1'b1;
        if (events[AL_ESTOP])
        begin
          alarm_main <= MAIN_ESTOP;
          alarm_sub  <= 8'h00;
        end
        else
        begin
          alarm_main <= MAIN_FIELDBUS;
          if (events[AL_TX_MAP])
            alarm_sub <= 8'h00;
          else if (events[AL_RX_MAP])
            alarm_sub <= 8'h01;
          else if (events[AL_LOST_LINK])
            alarm_sub <= 8'h02;
          else
            alarm_sub <= 8'h03;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and output
  // ----------------------------------------------------------------
  // a cause in the same cycle as the clearing read is kept
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      int_status_q <= '0;
    else
      int_status_q <= (rd_clear ? '0 : int_status_q) | events;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(int_status_q & int_mask_q);
  end

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  // address and data are taken in either order; the response goes out
  // one cycle after the later of the two arrives
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_hit = (waddr_q == OFS_TX_MAP_SIZE) || (waddr_q == OFS_RX_MAP_SIZE) ||
                  (waddr_q == OFS_LINK_TIME)   || (waddr_q == OFS_OD_VENDOR)   ||
                  (waddr_q == OFS_OD_PRODUCT)  || (waddr_q == OFS_OD_REVISION) ||
                  (waddr_q == OFS_INT_MASK);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      waddr_q       <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end
    else
    begin
      // ready pulses for one cycle when the half is taken
      s_axi_awready <= s_axi_awvalid && !aw_held_q && !s_axi_awready;
      s_axi_wready  <= s_axi_wvalid && !w_held_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        waddr_q   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_size_q     <= 8'h00;
      rx_size_q     <= 8'h00;
      link_time_q   <= LINK_TIME_RST;
      od_vendor_q   <= 32'h0000_0000;
      od_product_q  <= 32'h0000_0000;
      od_revision_q <= 32'h0000_0000;
      int_mask_q    <= INT_MASK_RST;
    end
    else if (wr_go)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wstrb_q[b])
        begin
          case (waddr_q)
            OFS_OD_VENDOR:   od_vendor_q[b*8 +: 8]   <= wdata_q[b*8 +: 8];
            OFS_OD_PRODUCT:  od_product_q[b*8 +: 8]  <= wdata_q[b*8 +: 8];
            OFS_OD_REVISION: od_revision_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
            default:         ;
          endcase
        end
      end
      // narrow registers live in the low lanes
      if (wstrb_q[0])
      begin
        case (waddr_q)
          OFS_TX_MAP_SIZE: tx_size_q        <= wdata_q[7:0];
          OFS_RX_MAP_SIZE: rx_size_q        <= wdata_q[7:0];
          OFS_LINK_TIME:   link_time_q[7:0] <= wdata_q[7:0];
          OFS_INT_MASK:    int_mask_q       <= wdata_q[NUM_ALARMS-1:0];
          default:         ;
        endcase
      end
      if (wstrb_q[1] && waddr_q == OFS_LINK_TIME)
        link_time_q[15:8] <= wdata_q[15:8];
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  assign rd_go    = s_axi_arvalid && s_axi_arready;
  assign rd_clear = rd_go && (s_axi_araddr == OFS_INT_STATUS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      // one read at a time: no new address while data waits
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr)
          OFS_TX_MAP_SIZE: s_axi_rdata <= {24'h000000, tx_size_q};
          OFS_RX_MAP_SIZE: s_axi_rdata <= {24'h000000, rx_size_q};
          OFS_LINK_TIME:   s_axi_rdata <= {16'h0000, link_time_q};
          OFS_OD_VENDOR:   s_axi_rdata <= od_vendor_q;
          OFS_OD_PRODUCT:  s_axi_rdata <= od_product_q;
          OFS_OD_REVISION: s_axi_rdata <= od_revision_q;
          OFS_ALARM_FLAGS: s_axi_rdata <= {27'h0000000, flags_q};
          OFS_ALARM_CODE:  s_axi_rdata <= {15'h0000, alarm_valid, alarm_main, alarm_sub};
          OFS_INT_STATUS:  s_axi_rdata <= {27'h0000000, int_status_q};
          OFS_INT_MASK:    s_axi_rdata <= {27'h0000000, int_mask_q};
          OFS_LINK_STATUS: s_axi_rdata <= {27'h0000000, active, watch, port_link};
          default:
          begin
            // unmapped: zero data and a slave error
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // fieldbus_alarm_checker

// file: rtl/alarm_pkg.sv
package alarm_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TX_MAP_SIZE  = 8'h00;  // transmit map size, bytes
  localparam logic [7:0] OFS_RX_MAP_SIZE  = 8'h04;  // receive map size, bytes
  localparam logic [7:0] OFS_LINK_TIME    = 8'h08;  // lost_link_detect_time, ms
  localparam logic [7:0] OFS_OD_VENDOR    = 8'h0C;  // dictionary vendor id
  localparam logic [7:0] OFS_OD_PRODUCT   = 8'h10;  // dictionary product code
  localparam logic [7:0] OFS_OD_REVISION  = 8'h14;  // dictionary revision
  localparam logic [7:0] OFS_ALARM_FLAGS  = 8'h18;  // sticky alarm flags
  localparam logic [7:0] OFS_ALARM_CODE   = 8'h1C;  // first alarm code
  localparam logic [7:0] OFS_INT_STATUS   = 8'h20;  // interrupt status, read clears
  localparam logic [7:0] OFS_INT_MASK     = 8'h24;  // interrupt mask
  localparam logic [7:0] OFS_LINK_STATUS  = 8'h28;  // port link and watch state

  // ----------------------------------------------------------------
  // alarm index, field positions and codes
  // ----------------------------------------------------------------
  localparam int          NUM_ALARMS      = 5;
  localparam int          AL_TX_MAP       = 0;      // main 85 sub 0
  localparam int          AL_RX_MAP       = 1;      // main 85 sub 1
  localparam int          AL_LOST_LINK    = 2;      // main 85 sub 2
  localparam int          AL_EEPROM       = 3;      // main 85 sub 3
  localparam int          AL_ESTOP        = 4;      // main 87 sub 0
  localparam logic [7:0]  MAIN_FIELDBUS   = 8'h55;  // 85 decimal
  localparam logic [7:0]  MAIN_ESTOP      = 8'h57;  // 87 decimal
  localparam int          CODE_VALID_BIT  = 16;     // alarm code register valid bit
  localparam logic [7:0]  MAP_LIMIT_BYTES = 8'h20;  // 32 bytes

  // ----------------------------------------------------------------
  // slave controller expected values
  // ----------------------------------------------------------------
  localparam logic [15:0] PDI_CTRL_EXPECT   = 16'h0C08;
  localparam logic [15:0] SYNC_CFG_EXPECT   = 16'h6600;
  localparam logic [15:0] SYNC_PULSE_EXPECT = 16'h0064;
  localparam int          SYNC_MAP_BIT      = 3;

  // ----------------------------------------------------------------
  // fieldbus state encodings
  // ----------------------------------------------------------------
  localparam logic [3:0]  ESM_INIT   = 4'h1;
  localparam logic [3:0]  ESM_PREOP  = 4'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ         = 10_000_000;
  localparam int          LINK_UNIT_US   = 1000;   // lost-link time unit, us
  localparam int          LINK_UNIT_CYC  = (CLK_HZ / 1_000_000) * LINK_UNIT_US;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] LINK_TIME_RST = 16'h0001;
  localparam logic [4:0]  INT_MASK_RST  = 5'h00;

  // ----------------------------------------------------------------
  // axi responses
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// file: rtl/lost_link_timer.sv
`timescale 1ns/10ps
module lost_link_timer
  import alarm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        tick,        // one-cycle unit pulse
  input  wire logic        arm,         // init to preop transition pulse
  input  wire logic        active,      // fieldbus state is past init
  input  wire logic        link_up,     // port link present
  input  wire logic [15:0] limit,       // units until expiry
  output logic             watch,       // port counted
  output logic             expired      // one-cycle expiry pulse
);

  logic [15:0] count_q;  // units spent without link

  // ----------------------------------------------------------------
  // watch state
  // ----------------------------------------------------------------
  // a port without link at arming is left out; once its link shows up
  // it is watched like the others, so a later drop still counts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      watch <= 1'b0;
    else if (arm)
      watch <= link_up;
    else if (!active)
      watch <= 1'b0;
    else if (link_up)
      watch <= 1'b1;
  end

  // ----------------------------------------------------------------
  // down-time counter
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q <= 16'h0000;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (arm || link_up || !watch || !active)
        count_q <= 16'h0000;
      else if (tick && count_q != 16'hFFFF)
      begin
        count_q <= count_q + 16'h0001;
        // fires once, on the limit-th tick after the drop, so between limit-1 and limit units after it
        if (count_q + 16'h0001 == limit)
          expired <= 1'b1;
      end
    end
  end

endmodule // lost_link_timer

// file: verif/fieldbus_alarm_monitor.sv
`timescale 1ns/10ps
// ----
// alarm assertions
// ----
module fieldbus_alarm_monitor
  import alarm_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        estop,
  input wire logic [15:0] pdi_control,
  input wire logic [15:0] sync_config,
  input wire logic [15:0] sync_pulse,
  input wire logic [7:0]  sync_event_map,
  input wire logic [7:0]  irq_map,
  input wire logic        alarm_valid,
  input wire logic [7:0]  alarm_main,
  input wire logic [7:0]  alarm_sub
);
  // one domain, so one clock and one reset serve every property
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  estop_latch_a: assert property (estop |=> alarm_valid)
    else $error("estop did not latch an alarm");
  estop_code_a: assert property (estop && !alarm_valid |=> alarm_main == MAIN_ESTOP && alarm_sub == 8'h00)
    else $error("estop gave a wrong first code");
  pdi_check_a: assert property (pdi_control != PDI_CTRL_EXPECT |=> alarm_valid)
    else $error("pdi control mismatch not latched");
  sync_cfg_a: assert property (sync_config != SYNC_CFG_EXPECT |=> alarm_valid)
    else $error("sync config mismatch not latched");
  sync_pulse_a: assert property (sync_pulse != SYNC_PULSE_EXPECT |=> alarm_valid)
    else $error("sync pulse mismatch not latched");
  irq_map_a: assert property (irq_map != 8'h00 |=> alarm_valid)
    else $error("irq map nonzero not latched");
  event_map_a: assert property (sync_event_map[SYNC_MAP_BIT] |=> alarm_valid)
    else $error("sync event mapping not latched");
  // the first code must survive any later cause until reset
  code_hold_a: assert property (alarm_valid |=> alarm_valid && $stable(alarm_main) && $stable(alarm_sub))
    else $error("latched alarm code changed");
endmodule // fieldbus_alarm_monitor

bind fieldbus_alarm_checker fieldbus_alarm_monitor fieldbus_alarm_monitor_i (
  .aclk(aclk), .aresetn(aresetn), .estop(estop), .pdi_control(pdi_control),
  .sync_config(sync_config), .sync_pulse(sync_pulse), .sync_event_map(sync_event_map),
  .irq_map(irq_map), .alarm_valid(alarm_valid), .alarm_main(alarm_main),
  .alarm_sub(alarm_sub));

// file: verif/fieldbus_partner.sv
`timescale 1ns/10ps
// ----
// eeprom and slave controller stand-in
// ----
module fieldbus_partner
  import alarm_pkg::*;
(
  input  wire logic [3:0] fault,       // fault to present, 0 = healthy
  output logic [31:0]     vendor_id,   // identity as read from eeprom
  output logic [31:0]     product,
  output logic [31:0]     revision,
  output logic            access_fail, // eeprom access went wrong
  output logic [15:0]     pdi_control,
  output logic [15:0]     sync_config,
  output logic [7:0]      event_map,
  output logic [7:0]      irq_map,
  output logic [15:0]     sync_pulse,
  output logic            estop
);
  // healthy identity is zero, matching the dictionary after reset
  assign vendor_id   = {31'h0, fault == 4'h1};
  assign product     = {31'h0, fault == 4'h2};
  assign revision    = {31'h0, fault == 4'h3};
  assign access_fail = fault == 4'h4;
  // controller registers keep expected values unless broken on purpose
  assign event_map   = (fault == 4'h5) ? 8'h08 : 8'h00;
  assign pdi_control = PDI_CTRL_EXPECT ^ {15'h0, fault == 4'h6};
  assign sync_config = SYNC_CFG_EXPECT ^ {15'h0, fault == 4'h7};
  assign sync_pulse  = SYNC_PULSE_EXPECT ^ {15'h0, fault == 4'h8};
  assign irq_map     = (fault == 4'h9) ? 8'h01 : 8'h00;
  assign estop       = fault == 4'hA;
endmodule // fieldbus_partner

// file: verif/tb_fieldbus_alarm_checker.sv
`timescale 1ns/10ps
module tb_fieldbus_alarm_checker
  import alarm_pkg::*;
;
  // ----
  // signals
  // ----
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, afail, estop, avalid, irq;
  logic [7:0] awaddr, araddr, emap, imap, amain, asub;
  logic [31:0] wdata, rdata, ven, prod, rev, rd_data;
  logic [1:0] bresp, rresp, port_link, rd_resp;
  logic [15:0] pdi, scfg, spulse;
  logic [3:0] esm, fault;
  int fails, n_checks, i;
  // {kind, main, sub}: kinds 1..A are partner faults, B/C oversize maps
  localparam logic [19:0] ROWS [12] = '{20'h15503, 20'h25503, 20'h35503, 20'h45503,
    20'h55503, 20'h65503, 20'h75503, 20'h85503, 20'h95503, 20'hA5700, 20'hB5500, 20'hC5501};
  fieldbus_partner fieldbus_partner_i (.fault(fault), .vendor_id(ven), .product(prod),
    .revision(rev), .access_fail(afail), .pdi_control(pdi), .sync_config(scfg),
    .event_map(emap), .irq_map(imap), .sync_pulse(spulse), .estop(estop));
  // short tick keeps the lost-link wait to a few dozen cycles
  fieldbus_alarm_checker #(.TICK_CYCLES(8)) fieldbus_alarm_checker_i (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .esm_state(esm), .port_link(port_link), .eeprom_vendor_id(ven), .eeprom_product(prod),
    .eeprom_revision(rev), .eeprom_access_fail(afail), .pdi_control(pdi),
    .sync_config(scfg), .sync_event_map(emap), .irq_map(imap), .sync_pulse(spulse),
    .estop(estop), .alarm_valid(avalid), .alarm_main(amain), .alarm_sub(asub), .irq(irq));
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ----
  // tasks
  // ----
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one transfer; starts on a fresh edge so no signal is driven twice at once
  task automatic axi(input logic rd, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    arvalid <= rd;
    rready <= rd;
    awvalid <= !rd;
    wvalid <= !rd;
    bready <= !rd;
    for (k = 0; k < 40; k++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      if ((bvalid && !rd) || (rvalid && rd)) break;
    end
    rd_data = rdata;
    rd_resp = rd ? rresp : bresp;
    bready <= 1'b0;
    rready <= 1'b0;
    if (k == 40)
    begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic do_reset();
    fault <= 4'h0;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // ----
  // sequence
  // ----
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {fault, esm, port_link} = {4'h0, ESM_INIT, 2'b11};
    fails = 0;
    n_checks = 0;
    foreach (ROWS[r])
    begin
      do_reset();
      if (ROWS[r][19:16] < 4'hB) fault <= ROWS[r][19:16];
      if (ROWS[r][19:16] == 4'hB) axi(1'b0, OFS_TX_MAP_SIZE, 32'h21);
      if (ROWS[r][19:16] == 4'hC) axi(1'b0, OFS_RX_MAP_SIZE, 32'h21);
      repeat (3) @(posedge aclk);
      chk({avalid, amain, asub}, {1'b1, ROWS[r][15:0]});
    end
    do_reset();
    @(posedge aclk);
    chk(avalid, 1'b0);
    axi(1'b1, OFS_LINK_TIME, 32'h0);
    chk(rd_data, {16'h0, LINK_TIME_RST});
    axi(1'b1, 8'h3C, 32'h0);
    chk(rd_resp, RESP_SLVERR);
    axi(1'b0, OFS_ALARM_FLAGS, 32'h1F);
    chk(rd_resp, RESP_SLVERR);
    axi(1'b0, OFS_TX_MAP_SIZE, 32'h20);
    axi(1'b0, OFS_RX_MAP_SIZE, 32'h20);
    axi(1'b0, OFS_INT_MASK, 32'h10);
    chk(avalid, 1'b0);
    axi(1'b0, OFS_TX_MAP_SIZE, 32'h21);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    fault <= 4'hA;
    repeat (3) @(posedge aclk);
    chk({irq, amain, asub}, {1'b1, MAIN_FIELDBUS, 8'h00});
    fault <= 4'h0;
    axi(1'b1, OFS_INT_STATUS, 32'h0);
    chk(rd_data, 32'h11);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    // lost link: port 1 already down at the transition must be ignored
    do_reset();
    port_link <= 2'b01;
    axi(1'b0, OFS_LINK_TIME, 32'h2);
    esm <= ESM_PREOP;
    repeat (40) @(posedge aclk);
    chk(avalid, 1'b0);
    port_link <= 2'b00;
    repeat (6) @(posedge aclk);
    chk(avalid, 1'b0);
    for (i = 0; i < 20 && avalid !== 1'b1; i++) @(posedge aclk);
    chk({avalid, amain, asub}, {1'b1, MAIN_FIELDBUS, 8'h02});
    // code, sticky flags and port watch state as software sees them
    axi(1'b1, OFS_ALARM_CODE, 32'h0);
    chk(rd_data, {15'h0, 1'b1, MAIN_FIELDBUS, 8'h02});
    axi(1'b1, OFS_ALARM_FLAGS, 32'h0);
    chk(rd_data, 32'h4);
    axi(1'b1, OFS_LINK_STATUS, 32'h0);
    chk(rd_data, 32'h14);
    report_and_stop();
  end
endmodule // tb_fieldbus_alarm_checker
